// file: hdl/desc_check_pkg.sv
/*
 Package for the descriptor permission checker and halt logic.
 Holds register offsets, field positions, operation codes and state types.
 Assumes a single 50 MHz clock domain and an APB register bus.
*/
package desc_check_pkg;

   // APB register byte offsets
   localparam logic [11:0] OFS_GENERAL_CONTROL = 12'h000;
   localparam logic [11:0] OFS_GENERAL_STATE   = 12'h004;
   localparam logic [11:0] OFS_INTERRUPT_CAUSE = 12'h008;
   localparam logic [11:0] OFS_CAPABILITY      = 12'h00c;
   localparam logic [11:0] OFS_RESET_COMMAND   = 12'h010;
   localparam logic [11:0] OFS_CHECK_COUNT     = 12'h014;

   // General control fields
   localparam int CTRL_HALT_INT_EN_BIT = 0;

   // General state fields
   localparam int STATE_LSB      = 0;
   localparam int RESET_TYPE_LSB = 8;

   // Interrupt cause fields
   localparam int CAUSE_HALT_BIT = 0;

   // Capability fields: supported entry types, offset mode
   localparam int CAP_TYPE0_BIT   = 0;
   localparam int CAP_TYPE1_BIT   = 1;
   localparam int CAP_OFFSET_BIT  = 2;
   localparam logic [31:0] CAP_RESET = 32'h0000_0007;

   // Reset command value that leaves halt (device reset class)
   localparam logic [31:0] RESET_DEVICE_CMD = 32'h0000_0001;

   // Operation codes of the checked descriptors
   typedef enum logic [4:0] {
      OP_DRAIN, OP_COMPARE, OP_COMPARE_PATTERN, OP_CREATE_DELTA,
      OP_CRC_GEN, OP_COPY_CRC, OP_DIF_CHECK, OP_ID_COPY, OP_ID_FILL,
      OP_ID_COMPARE, OP_ID_COMPARE_PATTERN, OP_UPDATE_WINDOW, OP_OTHER
   } op_t;

   typedef enum logic [1:0] {
      DEV_DISABLED = 2'h0,
      DEV_ENABLED  = 2'h1,
      DEV_HALTED   = 2'h2
   } dev_state_t;

   typedef enum logic [1:0] {
      RST_DEVICE_CMD = 2'h0,
      RST_FLR        = 2'h1,
      RST_WARM       = 2'h2,
      RST_COLD       = 2'h3
   } reset_type_t;

   // Completion status codes
   localparam logic [7:0] STS_SUCCESS   = 8'h01;
   localparam logic [7:0] STS_BAD_FLAGS = 8'h11;
   localparam logic [7:0] STS_RESERVED  = 8'h12;
   localparam logic [7:0] STS_PERM      = 8'h20;

   // Entry type values
   localparam logic [1:0] ENTRY_TYPE_SINGLE = 2'h0;
   localparam logic [1:0] ENTRY_TYPE_BITMAP = 2'h1;
   localparam int         PASID_W           = 20;

endpackage

// file: hdl/desc_check.sv
/*
 Descriptor flag/permission checker with device halt state and APB registers.
 Assumes descriptor and entry fields arrive already fetched, held for one
 valid cycle; the submitter bitmap bit is looked up outside and supplied.
*/
// The implementer's own choices: the APB register port and the register addresses.
// How it works
// - Referenced entry reserved fields must all be zero.
// - Entry type must be reported supported by capability register.
// - Enabled window needs nonzero size and no wrap past 2^64.
// - Every referenced entry must be marked usable; only inter-domain operations check it, not update window.
// - Source entries need read permission, destination entries write permission.
// - Type 0 entry: descriptor identifier equals stored submitter identifier.
// - Type 1 entry: bitmap bit at descriptor identifier must be set.
// - Absolute window: start and end both lie inside base..base+size.
// - Offset window: address below size, address plus length within size.
// - Update window needs allow-update bit and matching access identifier.
// - Status shows device state and the least reset type to recover.
// - Entering halt sets halt cause and, if enabled, pulses vector 0.
// - Halt on unsupported config change or register/buffer parity error.
// - Halted device stops upstream traffic but still answers register reads.
// - Halted device answers every new submission with retry.
// - Halted device keeps invalidation completions unless fabric error or reset.
// - Config writable when disabled stays writable when halted.
`timescale 1ns/1ps
module desc_check
   import desc_check_pkg::*;
(
   // Clock and reset
   input  wire logic                 core_clk_in,
   input  wire logic                 rst_n_in,
   // APB slave
   input  wire logic                 psel_in,
   input  wire logic                 penable_in,
   input  wire logic                 pwrite_in,
   input  wire logic [11:0]          paddr_in,
   input  wire logic [31:0]          pwdata_in,
   output logic      [31:0]          prdata_out,
   output logic                      pready_out,
   output logic                      pslverr_out,
   // Descriptor submission
   input  wire logic                 desc_valid_in,
   input  wire op_t                  desc_op_in,
   input  wire logic [PASID_W-1:0]   desc_pasid_in,
   input  wire logic                 flag_cr_valid_in,
   input  wire logic                 flag_req_cr_in,
   input  wire logic                 flag_req_int_in,
   input  wire logic                 alt_src_in,
   input  wire logic                 alt_dst_in,
   input  wire logic [63:0]          addr_in,
   input  wire logic [63:0]          xfer_size_in,
   input  wire logic                 addr_is_dst_in,
   // Referenced permission table entry
   input  wire logic                 entry_rsvd_nz_in,
   input  wire logic [1:0]           entry_type_in,
   input  wire logic                 entry_usable_in,
   input  wire logic                 entry_read_in,
   input  wire logic                 entry_write_in,
   input  wire logic                 entry_allow_update_in,
   input  wire logic [PASID_W-1:0]   entry_submitter_in,
   input  wire logic [PASID_W-1:0]   entry_access_in,
   input  wire logic                 entry_bitmap_bit_in,
   input  wire logic                 entry_win_en_in,
   input  wire logic                 entry_win_mode_in,
   input  wire logic [63:0]          entry_win_base_in,
   input  wire logic [63:0]          entry_win_size_in,
   // Error and reset events (pins, synchronised)
   input  wire logic                 bme_cleared_in,
   input  wire logic                 reg_parity_err_in,
   input  wire logic                 buf_parity_err_in,
   input  wire logic                 fabric_err_in,
   input  wire logic                 pcie_reset_in,
   input  wire logic                 inval_req_in,
   // Results
   output logic                      done_out,
   output logic [7:0]                done_status_out,
   output logic                      mem_go_out,
   output logic                      retry_out,
   output logic                      upstream_en_out,
   output logic                      inval_cpl_out,
   output logic                      msix_vec0_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers for the asynchronous error inputs
   logic [5:0] sync1;
   logic [5:0] sync2;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1 <= 6'h00;
         sync2 <= 6'h00;
      end else begin
         sync1 <= {inval_req_in, pcie_reset_in, fabric_err_in, buf_parity_err_in,
                   reg_parity_err_in, bme_cleared_in};
         sync2 <= sync1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Descriptor checks
   logic        flags_ok;
   logic        entry_used;
   logic        rsvd_ok;
   logic        perm_ok;
   logic [64:0] win_end;
   logic [64:0] rng_end;
   logic [64:0] addr_ext;
   logic        win_ok;
   logic        inter_dom;
   logic        cap_type_ok;
   logic [31:0] capability;

   always_comb begin
      flags_ok = 1'b1;
      case (desc_op_in)
         OP_DRAIN:              flags_ok = flag_req_cr_in | flag_req_int_in;
         OP_COMPARE, OP_COMPARE_PATTERN, OP_CREATE_DELTA, OP_CRC_GEN, OP_COPY_CRC, OP_DIF_CHECK:
            flags_ok = flag_cr_valid_in & flag_req_cr_in;
         OP_ID_COPY:            flags_ok = alt_src_in | alt_dst_in;
         OP_ID_FILL:            flags_ok = alt_dst_in;
         OP_ID_COMPARE:         flags_ok = alt_src_in | alt_dst_in;
         OP_ID_COMPARE_PATTERN: flags_ok = alt_src_in;
         default:               flags_ok = 1'b1;
      endcase
   end

   // Entry checks; wide sums keep the 2^64 carry visible
   always_comb begin
      inter_dom   = (desc_op_in inside {OP_ID_COPY, OP_ID_FILL, OP_ID_COMPARE, OP_ID_COMPARE_PATTERN});
      entry_used  = inter_dom | (desc_op_in == OP_UPDATE_WINDOW);
      addr_ext    = {1'b0, addr_in};
      win_end     = {1'b0, entry_win_base_in} + {1'b0, entry_win_size_in};
      rng_end     = addr_ext + {1'b0, xfer_size_in};
      cap_type_ok = (entry_type_in == ENTRY_TYPE_SINGLE) ? capability[CAP_TYPE0_BIT] :
                    (entry_type_in == ENTRY_TYPE_BITMAP) ? capability[CAP_TYPE1_BIT] : 1'b0;
      rsvd_ok     = !entry_rsvd_nz_in
                    && cap_type_ok
                    && !(entry_win_en_in && entry_win_mode_in && !capability[CAP_OFFSET_BIT]);
      if (entry_win_en_in) begin
         rsvd_ok = rsvd_ok && (entry_win_size_in != 64'h0)
                   && (win_end <= {1'b1, 64'h0});
      end
      perm_ok = 1'b1;
      win_ok  = 1'b1;
      if (inter_dom) begin
         perm_ok = entry_usable_in
                   && (addr_is_dst_in ? entry_write_in : entry_read_in);
         if (entry_type_in == ENTRY_TYPE_SINGLE) begin
            perm_ok = perm_ok && (desc_pasid_in == entry_submitter_in);
         end else begin
            perm_ok = perm_ok && entry_bitmap_bit_in;
         end
         if (entry_win_en_in && !entry_win_mode_in) begin
            win_ok = (addr_ext >= {1'b0, entry_win_base_in}) && (addr_ext < win_end)
                     && (rng_end > {1'b0, entry_win_base_in}) && (rng_end <= win_end);
         end else if (entry_win_en_in) begin
            win_ok = (addr_ext < {1'b0, entry_win_size_in})
                     && (rng_end <= {1'b0, entry_win_size_in});
         end
      end
      if (desc_op_in == OP_UPDATE_WINDOW) begin
         perm_ok = entry_allow_update_in && (desc_pasid_in == entry_access_in);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Device state machine and registers
   dev_state_t  dev_state;
   dev_state_t  next_dev_state;
   reset_type_t reset_type;
   reset_type_t next_reset_type;
   logic        halt_int_en;
   logic        next_halt_int_en;
   logic        halt_cause;
   logic        next_halt_cause;
   logic [31:0] next_capability;
   logic [15:0] check_count;
   logic [15:0] next_check_count;
   logic        halt_evt;
   logic        enter_halt;
   logic        wr_acc;
   logic        rd_acc;

   always_comb begin
      wr_acc   = psel_in & penable_in & pwrite_in;
      // Reads are latched in setup so the data already stands in the access phase
      rd_acc   = psel_in & !penable_in & !pwrite_in;
      halt_evt = sync2[0] | sync2[1] | sync2[2] | sync2[3];
      enter_halt       = halt_evt && (dev_state != DEV_HALTED);
      next_dev_state   = dev_state;
      next_reset_type  = reset_type;
      next_halt_int_en = halt_int_en;
      next_halt_cause  = halt_cause;
      next_capability  = capability;
      next_check_count = check_count;
      // Control writable in disabled and also in halted state
      if (wr_acc && paddr_in == OFS_GENERAL_CONTROL) begin
         next_halt_int_en = pwdata_in[CTRL_HALT_INT_EN_BIT];
         if (dev_state == DEV_DISABLED) begin
            next_dev_state = DEV_ENABLED;
         end
      end
      if (wr_acc && paddr_in == OFS_CAPABILITY && dev_state != DEV_ENABLED) begin
         next_capability = pwdata_in;
      end
      // Write-one-to-clear; a new halt entry wins over the clear
      if (wr_acc && paddr_in == OFS_INTERRUPT_CAUSE && pwdata_in[CAUSE_HALT_BIT]) begin
         next_halt_cause = 1'b0;
      end
      // Device reset command only recovers when that class suffices
      if (wr_acc && paddr_in == OFS_RESET_COMMAND && pwdata_in == RESET_DEVICE_CMD
          && reset_type == RST_DEVICE_CMD) begin
         next_dev_state = DEV_DISABLED;
      end
      if (desc_valid_in && dev_state == DEV_ENABLED) begin
         next_check_count = check_count + 16'h0001;
      end
      if (enter_halt) begin
         next_dev_state  = DEV_HALTED;
         next_halt_cause = 1'b1;
         // Parity faults need a function reset; fabric faults a warm reset
         next_reset_type = sync2[3] ? RST_WARM :
                           (sync2[1] | sync2[2]) ? RST_FLR : RST_DEVICE_CMD;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dev_state   <= DEV_DISABLED;
         reset_type  <= RST_DEVICE_CMD;
         halt_int_en <= 1'b0;
         halt_cause  <= 1'b0;
         capability  <= CAP_RESET;
         check_count <= 16'h0000;
      end else begin
         dev_state   <= next_dev_state;
         reset_type  <= next_reset_type;
         halt_int_en <= next_halt_int_en;
         halt_cause  <= next_halt_cause;
         capability  <= next_capability;
         check_count <= next_check_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered results
   logic        next_done;
   logic [7:0]  next_status;
   logic        next_mem_go;
   logic        next_retry;
   logic        next_inval;
   logic        next_msix;
   logic [31:0] next_prdata;

   always_comb begin
      next_done   = 1'b0;
      next_status = done_status_out;
      next_mem_go = 1'b0;
      next_retry  = desc_valid_in && (dev_state != DEV_ENABLED);
      if (desc_valid_in && dev_state == DEV_ENABLED) begin
         next_done = 1'b1;
         if (!flags_ok) begin
            next_status = STS_BAD_FLAGS;
         end else if (entry_used && !rsvd_ok) begin
            next_status = STS_RESERVED;
         end else if (entry_used && !(perm_ok && win_ok)) begin
            next_status = STS_PERM;
         end else begin
            next_status = STS_SUCCESS;
            next_mem_go = 1'b1;
         end
      end
      next_inval = sync2[5] && !(dev_state == DEV_HALTED && (sync2[3] || sync2[4]));
      next_msix  = enter_halt && halt_int_en;
      // Register reads keep answering while halted
      case (paddr_in)
         OFS_GENERAL_CONTROL: next_prdata = {31'h0, halt_int_en};
         OFS_GENERAL_STATE:   next_prdata = {22'h0, reset_type, 6'h0, dev_state};
         OFS_INTERRUPT_CAUSE: next_prdata = {31'h0, halt_cause};
         OFS_CAPABILITY:      next_prdata = capability;
         OFS_CHECK_COUNT:     next_prdata = {16'h0, check_count};
         default:             next_prdata = 32'h0;
      endcase
      if (!rd_acc) begin
         next_prdata = prdata_out;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         done_out        <= 1'b0;
         done_status_out <= 8'h00;
         mem_go_out      <= 1'b0;
         retry_out       <= 1'b0;
         inval_cpl_out   <= 1'b0;
         msix_vec0_out   <= 1'b0;
         prdata_out      <= 32'h0;
      end else begin
         done_out        <= next_done;
         done_status_out <= next_status;
         mem_go_out      <= next_mem_go;
         retry_out       <= next_retry;
         inval_cpl_out   <= next_inval;
         msix_vec0_out   <= next_msix;
         prdata_out      <= next_prdata;
      end
   end

   // Zero-wait APB; unmapped offsets flag an error
   always_comb begin
      pready_out  = 1'b1;
      pslverr_out = psel_in & penable_in &
                    !(paddr_in inside {OFS_GENERAL_CONTROL, OFS_GENERAL_STATE, OFS_INTERRUPT_CAUSE,
                                       OFS_CAPABILITY, OFS_RESET_COMMAND, OFS_CHECK_COUNT});
      upstream_en_out = (dev_state == DEV_ENABLED);
   end

endmodule

// file: tb/desc_check_chk.sv
/*
 Checker for desc_check: completions, retry, halt entry, invalidations.
 Assumes it is bound to desc_check and sees its ports only.
*/
`timescale 1ns/1ps
module desc_check_chk
   import desc_check_pkg::*;
(
   // Clock, reset and inputs
   input wire logic       core_clk_in,
   input wire logic       rst_n_in,
   input wire logic       desc_valid_in,
   input wire logic       bme_cleared_in,
   input wire logic       fabric_err_in,
   // Outputs watched
   input wire logic       done_out,
   input wire logic [7:0] done_status_out,
   input wire logic       mem_go_out,
   input wire logic       retry_out,
   input wire logic       upstream_en_out,
   input wire logic       inval_cpl_out,
   input wire logic       msix_vec0_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////
   // Memory work only for clean completions
   a_fail_no_mem: assert property (done_out && done_status_out != STS_SUCCESS |-> !mem_go_out)
      else $error("failed descriptor did memory work");
   a_go_needs_ok: assert property (mem_go_out |-> done_out && done_status_out == STS_SUCCESS)
      else $error("memory work without success");
   a_enabled_done: assert property (desc_valid_in && upstream_en_out |=> done_out)
      else $error("descriptor not completed");
   // Retry stands alone and answers when not running
   a_idle_retry: assert property (desc_valid_in && !upstream_en_out |=> retry_out)
      else $error("no retry while not enabled");
   a_retry_alone: assert property (retry_out |-> !done_out && !mem_go_out)
      else $error("retry mixed with completion");
   // Halt entry; range covers the two-flop sync
   a_bme_halts: assert property ($rose(bme_cleared_in) |-> ##[1:6] !upstream_en_out)
      else $error("no halt after bus master cleared");
   a_irq_at_halt: assert property (msix_vec0_out |-> $fell(upstream_en_out))
      else $error("halt interrupt outside halt entry");
   a_fabric_no_inv: assert property (fabric_err_in [*6] |-> !inval_cpl_out)
      else $error("invalidation after fabric error");
endmodule

// file: tb/host_model.sv
/*
 Host-side descriptor source: completion and address-space flags.
 Assumes the bench picks the operation and when to break the flags.
*/
`timescale 1ns/1ps
module host_model
   import desc_check_pkg::*;
(
   // Request from the bench
   input  wire op_t  op_in,
   input  wire logic bad_in,
   // Flags to the device
   output logic      cr_valid_out,
   output logic      req_cr_out,
   output logic      req_int_out,
   output logic      alt_src_out,
   output logic      alt_dst_out
);
   // Legal sets carry the needed flags plus completion-valid and, except for drain, request-completion; a broken set drops the one that is needed
   always_comb begin
      cr_valid_out = !bad_in;
      req_cr_out   = op_in != OP_DRAIN;
      req_int_out  = !bad_in && op_in == OP_DRAIN;
      alt_src_out  = !bad_in && !(op_in inside {OP_ID_FILL, OP_ID_COPY});
      alt_dst_out  = !bad_in && (op_in inside {OP_ID_FILL, OP_ID_COPY});
   end
endmodule

// file: tb/desc_check_tb.sv
/*
 Bench for desc_check: flag table, entry checks, halts, APB registers.
 Assumes host_model drives the flags; the checker is bound at the foot.
*/
`timescale 1ns/1ps
module desc_check_tb
   import desc_check_pkg::*;
;
   localparam logic [PASID_W-1:0] PID   = 20'h00abc;
   localparam logic [7:0]         ANY   = 8'h00;
   localparam logic [7:0]         RETRY = 8'hff;
   typedef struct {op_t op; logic [7:0] bad_st;} row_t;
   ////////////////////////////////////////
   // Design ports
   logic        core_clk_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, rdv;
   logic        desc_valid_in, bad, err, flag_cr_valid_in, flag_req_cr_in, flag_req_int_in, alt_src_in, alt_dst_in;
   op_t         desc_op_in;
   logic [PASID_W-1:0] desc_pasid_in, entry_submitter_in, entry_access_in;
   logic [63:0] addr_in, xfer_size_in, entry_win_base_in, entry_win_size_in;
   logic [1:0]  entry_type_in;
   logic        addr_is_dst_in, entry_rsvd_nz_in, entry_usable_in, entry_read_in, entry_write_in;
   logic        entry_allow_update_in, entry_bitmap_bit_in, entry_win_en_in, entry_win_mode_in;
   logic        bme_cleared_in, reg_parity_err_in, buf_parity_err_in, fabric_err_in, pcie_reset_in, inval_req_in;
   logic        done_out, mem_go_out, retry_out, upstream_en_out, inval_cpl_out, msix_vec0_out;
   logic [7:0]  done_status_out;
   int          mismatches = 0;
   int          check_count = 0;
   int          n;
   // Each operation, flag-bearing or not: legal, then with flags broken
   row_t rows [13] = '{'{OP_DRAIN, STS_BAD_FLAGS}, '{OP_COMPARE, STS_BAD_FLAGS},
      '{OP_COMPARE_PATTERN, STS_BAD_FLAGS}, '{OP_CREATE_DELTA, STS_BAD_FLAGS}, '{OP_CRC_GEN, STS_BAD_FLAGS},
      '{OP_COPY_CRC, STS_BAD_FLAGS}, '{OP_DIF_CHECK, STS_BAD_FLAGS}, '{OP_ID_COPY, STS_BAD_FLAGS},
      '{OP_ID_FILL, STS_BAD_FLAGS}, '{OP_ID_COMPARE, STS_BAD_FLAGS}, '{OP_ID_COMPARE_PATTERN, STS_BAD_FLAGS},
      '{OP_UPDATE_WINDOW, STS_SUCCESS}, '{OP_OTHER, STS_SUCCESS}};
   desc_check dut (.*);
   host_model u_host (.op_in(desc_op_in), .bad_in(bad), .cr_valid_out(flag_cr_valid_in),
      .req_cr_out(flag_req_cr_in), .req_int_out(flag_req_int_in), .alt_src_out(alt_src_in), .alt_dst_out(alt_dst_in));
   ////////////////////////////////////////
   // Clock and watchdog
   initial begin
      core_clk_in = 1'h0;
      forever #10 core_clk_in = ~core_clk_in;
   end
   initial begin
      repeat (5000) @(posedge core_clk_in);
      mismatches++;
      report_and_stop();
   end
   // Shared checks and bus cycles
   task cmp(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {1'h1, 1'h0, w, a, d};
      @(posedge core_clk_in);
      penable_in <= 1'h1;
      @(posedge core_clk_in);
      while (pready_out !== 1'h1) @(posedge core_clk_in);
      rdv = prdata_out;
      err = pslverr_out;
      {psel_in, penable_in} <= 2'h0;
   endtask
   // Read data is taken at the access edge itself
   task rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      cmp(rdv, exp);
   endtask
   task defaults();
      {entry_rsvd_nz_in, entry_type_in, entry_usable_in, entry_read_in, entry_write_in} <= 6'h07;
      {entry_allow_update_in, entry_bitmap_bit_in, entry_win_en_in, entry_win_mode_in, addr_is_dst_in} <= 5'h18;
      {entry_submitter_in, entry_access_in} <= {PID, PID};
      {addr_in, xfer_size_in, entry_win_base_in, entry_win_size_in} <= {64'h0, 64'h1, 128'h0};
   endtask
   // Called at a rising edge; fields set at that edge go with the pulse
   task desc(input op_t op, input logic b, input logic [7:0] st);
      {desc_valid_in, desc_op_in, bad} <= {1'h1, op, b};
      @(posedge core_clk_in);
      {desc_valid_in, bad} <= 2'h0;
      defaults();
      @(negedge core_clk_in);
      cmp(retry_out, st == RETRY);
      cmp(done_out, st != RETRY);
      cmp(mem_go_out, st == STS_SUCCESS);
      if (st != ANY && st != RETRY)
         cmp(done_status_out, st);
      @(posedge core_clk_in);
   endtask
   task win(input logic m, input logic [63:0] b, s, a, x, input logic [7:0] st);
      {entry_win_en_in, entry_win_mode_in, entry_win_base_in, entry_win_size_in} <= {1'h1, m, b, s};
      {addr_in, xfer_size_in} <= {a, x};
      desc(OP_ID_COPY, 1'h0, st);
   endtask
   task report_and_stop();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////
   // Main sequence
   initial begin
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, desc_valid_in, bad} <= 49'h0;
      {desc_op_in, desc_pasid_in} <= {OP_OTHER, PID};
      {bme_cleared_in, reg_parity_err_in, buf_parity_err_in, fabric_err_in, pcie_reset_in, inval_req_in} <= 6'h0;
      defaults();
      rst_n_in <= 1'h0;
      repeat (2) @(posedge core_clk_in);
      rst_n_in <= 1'h1;
      rd(OFS_CAPABILITY, CAP_RESET);
      rd(OFS_GENERAL_STATE, 32'h0);
      desc(OP_OTHER, 1'h0, RETRY);
      apb(1'h0, 12'h020, 32'h0);
      cmp(err, 1'h1);
      apb(1'h1, OFS_GENERAL_CONTROL, 32'h1);
      rd(OFS_GENERAL_STATE, 32'h1);
      $display("test reset finished");
      foreach (rows[i]) begin
         desc(rows[i].op, 1'h0, STS_SUCCESS);
         desc(rows[i].op, 1'h1, rows[i].bad_st);
      end
      $display("test flags finished");
      entry_rsvd_nz_in <= 1'h1;
      desc(OP_ID_COPY, 1'h0, STS_RESERVED);
      entry_type_in <= 2'h2;
      desc(OP_ID_COPY, 1'h0, STS_RESERVED);
      entry_usable_in <= 1'h0;
      desc(OP_ID_COPY, 1'h0, STS_PERM);
      entry_read_in <= 1'h0;
      desc(OP_ID_COPY, 1'h0, STS_PERM);
      {entry_read_in, addr_is_dst_in} <= 2'h1;
      desc(OP_ID_COPY, 1'h0, STS_SUCCESS);
      {entry_write_in, addr_is_dst_in} <= 2'h1;
      desc(OP_ID_COPY, 1'h0, STS_PERM);
      entry_submitter_in <= PID + 20'h1;
      desc(OP_ID_COPY, 1'h0, STS_PERM);
      {entry_type_in, entry_bitmap_bit_in} <= {ENTRY_TYPE_BITMAP, 1'h0};
      desc(OP_ID_COPY, 1'h0, STS_PERM);
      {entry_type_in, entry_submitter_in} <= {ENTRY_TYPE_BITMAP, PID + 20'h1};
      desc(OP_ID_COPY, 1'h0, STS_SUCCESS);
      entry_allow_update_in <= 1'h0;
      desc(OP_UPDATE_WINDOW, 1'h0, STS_PERM);
      entry_access_in <= PID + 20'h1;
      desc(OP_UPDATE_WINDOW, 1'h0, STS_PERM);
      $display("test entry finished");
      win(1'h0, 64'h1000, 64'h0, 64'h1000, 64'h1, STS_RESERVED);
      win(1'h0, 64'hffff_ffff_ffff_ff00, 64'h100, 64'hffff_ffff_ffff_ff00, 64'h100, STS_SUCCESS);
      win(1'h0, 64'hffff_ffff_ffff_ff00, 64'h101, 64'hffff_ffff_ffff_ff00, 64'h100, STS_RESERVED);
      win(1'h0, 64'h1000, 64'h100, 64'h1000, 64'h100, STS_SUCCESS);
      win(1'h0, 64'h1000, 64'h100, 64'h0fff, 64'h1, STS_PERM);
      win(1'h0, 64'h1000, 64'h100, 64'h1001, 64'h100, STS_PERM);
      win(1'h1, 64'h1000, 64'h100, 64'h00ff, 64'h1, STS_SUCCESS);
      win(1'h1, 64'h1000, 64'h100, 64'h0080, 64'h81, STS_PERM);
      win(1'h1, 64'h1000, 64'h100, 64'h1000, 64'h1, STS_PERM);
      $display("test window finished");
      bme_cleared_in <= 1'h1;
      for (n = 0; n < 8 && msix_vec0_out !== 1'h1; n++) @(negedge core_clk_in);
      cmp(msix_vec0_out, 1'h1);
      cmp(upstream_en_out, 1'h0);
      rd(OFS_GENERAL_STATE, 32'h0000_0002);
      rd(OFS_INTERRUPT_CAUSE, 32'h1);
      apb(1'h1, OFS_INTERRUPT_CAUSE, 32'h1);
      rd(OFS_INTERRUPT_CAUSE, 32'h0);
      desc(OP_ID_COPY, 1'h0, RETRY);
      inval_req_in <= 1'h1;
      for (n = 0; n < 8 && inval_cpl_out !== 1'h1; n++) @(negedge core_clk_in);
      cmp(inval_cpl_out, 1'h1);
      @(posedge core_clk_in);
      {bme_cleared_in, inval_req_in} <= 2'h0;
      apb(1'h1, OFS_CAPABILITY, 32'h3);
      rd(OFS_CAPABILITY, 32'h3);
      apb(1'h1, OFS_RESET_COMMAND, RESET_DEVICE_CMD);
      rd(OFS_GENERAL_STATE, 32'h0);
      $display("test halt finished");
      // Enable with the halt interrupt off: cause still set, no pulse
      apb(1'h1, OFS_GENERAL_CONTROL, 32'h0);
      reg_parity_err_in <= 1'h1;
      n = 0;
      repeat (8) @(negedge core_clk_in) n += (msix_vec0_out !== 1'h0);
      cmp(n, 0);
      rd(OFS_GENERAL_STATE, 32'h0000_0102);
      rd(OFS_INTERRUPT_CAUSE, 32'h1);
      {reg_parity_err_in, rst_n_in} <= 2'h0;
      repeat (2) @(posedge core_clk_in);
      rst_n_in <= 1'h1;
      rd(OFS_GENERAL_STATE, 32'h0);
      apb(1'h1, OFS_GENERAL_CONTROL, 32'h1);
      {fabric_err_in, inval_req_in} <= 2'h3;
      repeat (8) @(negedge core_clk_in);
      cmp(inval_cpl_out, 1'h0);
      rd(OFS_GENERAL_STATE, 32'h0000_0202);
      {fabric_err_in, inval_req_in} <= 2'h0;
      $display("test parity and fabric finished");
      report_and_stop();
   end
endmodule
bind desc_check desc_check_chk u_chk (.*);
